// File: aob_params.svh
`ifndef AOB_PARAMS_SVH
`define AOB_PARAMS_SVH
`define AOB_ADDR_OUT_MODE 8'h08
`define AOB_ADDR_TEST_PAT 8'h0d
`define AOB_ADDR_ST_CTRL 8'h0e
`define AOB_ADDR_ST_RES 8'h24
`define AOB_REG_RST 8'h00
`define AOB_OUT_DIS_MSB 6
`define AOB_OUT_DIS_LSB 5
`define AOB_OUT_DIS_PIN_MODE 2'b00
`define AOB_ST_EN_BIT 0
`define AOB_ST_RESTART_BIT 2
`define AOB_ST_PASS_BIT 0
`define AOB_PN_SHORT_RST_BIT 4
`define AOB_PN_LONG_RST_BIT 5
`define AOB_PAT_MSB 3
`define AOB_PAT_OFF 4'h0
`define AOB_PAT_MID 4'h1
`define AOB_PAT_POS_FS 4'h2
`define AOB_PAT_NEG_FS 4'h3
`define AOB_PAT_CHECKER 4'h4
`define AOB_PAT_PN_LONG 4'h5
`define AOB_PAT_PN_SHORT 4'h6
`define AOB_PAT_TOGGLE 4'h7
`define AOB_CODE_MIN 12'h000
`define AOB_CODE_MID 12'h800
`define AOB_CODE_MAX 12'hfff
`define AOB_CODE_CHECKER 12'haaa
`define AOB_LATENCY 9
`define AOB_ST_CYCLES 11'd512
`define AOB_ST_SIG 16'h0000
`define AOB_CRC_POLY 16'h1021
`define AOB_CRC_SEED 16'hffff
`define AOB_PN_LONG_TAPS 23'h420000
`define AOB_PN_LONG_SEED 23'h7fffff
`define AOB_PN_SHORT_TAPS 15'h6000
`define AOB_PN_SHORT_SEED 15'h7fff
`define AOB_ST_PN_TAPS 16'hb400
`define AOB_ST_PN_SEED 16'hffff
`endif

// File: aob_pkg.sv
`default_nettype none
package aob_pkg;
  typedef struct packed {
    logic ovr;
    logic [11:0] code;
  } aob_sample_s;
  typedef struct packed {
    logic sclk;
    logic over;
    logic under;
    logic [11:0] code;
    logic out_dis;
    logic fmt;
    logic pdown;
  } aob_pin_s;
  typedef enum logic [1:0] {
    AOB_ST_IDLE = 2'b00,
    AOB_ST_RUN = 2'b01,
    AOB_ST_CHECK = 2'b10
  } aob_st_e;
  typedef enum logic [1:0] {
    AOB_FMT_OFFSET = 2'b00,
    AOB_FMT_TWOS = 2'b01,
    AOB_FMT_GRAY = 2'b10
  } aob_fmt_e;
endpackage
`default_nettype wire

// File: aob_pn_gen.sv
`default_nettype none
module aob_pn_gen
  import aob_pkg::*;
#(
  parameter int W = 23,
  parameter logic [W-1:0] TAPS = '1,
  parameter logic [W-1:0] SEED = '1,
  parameter int OW = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Control
  input wire logic seed,
  input wire logic adv,
  // Pattern
  output logic [OW-1:0] word
);
  logic [W-1:0] state_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= SEED;
    else if (ce)
    begin
      if (seed)
        state_q <= SEED;
      else if (adv)
        state_q <= {state_q[W-2:0], ^(state_q & TAPS)};
    end
  end

  assign word = state_q[OW-1:0];
endmodule
`default_nettype wire

// File: aob_crc.sv
`default_nettype none
module aob_crc
  import aob_pkg::*;
#(
  parameter int W = 16,
  parameter logic [W-1:0] POLY = '1,
  parameter logic [W-1:0] SEED = '1,
  parameter int DW = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Control and data
  input wire logic clear,
  input wire logic en,
  input wire logic [DW-1:0] data,
  // Signature
  output logic [W-1:0] crc
);
  logic [W-1:0] crc_q;

  function automatic logic [W-1:0] crc_step(input logic [W-1:0] c,
                                            input logic [DW-1:0] d);
    logic [W-1:0] r;
    logic fb;
    r = c;
    for (int i = DW - 1; i >= 0; i--)
    begin
      fb = r[W-1] ^ d[i];
      r = {r[W-2:0], 1'b0};
      if (fb)
        r = r ^ POLY;
    end
    return r;
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      crc_q <= SEED;
    else if (ce)
    begin
      if (clear)
        crc_q <= SEED;
      else if (en)
        crc_q <= crc_step(crc_q, data);
    end
  end

  assign crc = crc_q;
endmodule
`default_nettype wire

// File: aob_backend.sv
// Overview of operation
// - Output-disable pin acts only when out-mode field bits 6:5 select it.
// - With that function on, pin low drives outputs; pin high floats them.
// - Each sample reaches the data outputs nine sample-clock edges later.
// - Data outputs update on each sample-clock rising edge.
// - A forwarded clock is driven; its polarity can be inverted.
// - Offset binary 000..fff, midscale 800; two's complement flips the top bit.
// - Over-range beyond half an LSB sets the flag and clamps the code.
// - Self-test feeds a pseudorandom word into the datapath and signs its output.
// - Self-test runs for exactly 512 cycles and stops alone.
// - At the end a matching signature sets result bit 0, else clears it.
// - Outputs stay connected during self-test so the sequence is visible.
// - Writing 0x05 to the self-test control starts it and reseeds the generator.
// - At completion the self-test enable bit clears itself.
// - Without restart the generator continues from its last state.
// - A selected output test pattern replaces the core and passes formatting.
// - Pattern-select bits 4 and 5 reset the two pattern generators.
// - Patterns ignore the analog input and advance only on sample edges.
// - Without serial control the format pin picks offset binary or two's complement.
// - Under serial control Gray code is also offered.
// - Powered down, all output drivers float.
`default_nettype none
`include "aob_params.svh"
module aob_backend
  import aob_pkg::*;
#(
  parameter int LATENCY = `AOB_LATENCY,
  parameter logic [15:0] ST_SIGNATURE = `AOB_ST_SIG
) (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Static configuration
  input wire logic serial_mode,
  input wire logic [1:0] fmt_cfg,
  input wire logic fwd_clk_invert,
  // Converter core and control pins
  input wire logic sample_clk_pin,
  input wire logic [11:0] core_code,
  input wire logic core_over,
  input wire logic core_under,
  input wire logic output_disable_pin,
  input wire logic format_select_pin,
  input wire logic powerdown_select_pin,
  // Output bus
  output logic [11:0] data_out,
  output logic over_range_out,
  output logic bus_oe,
  output logic forwarded_data_clock,
  output logic fwd_clk_oe
);
  aob_pin_s pin_in;
  aob_pin_s pin_s1_q;
  aob_pin_s pin_s2_q;
  logic sclk_d_q;
  logic sample_rise;
  logic [7:0] out_mode_q;
  logic [7:0] test_pat_q;
  logic [7:0] st_ctrl_q;
  logic [7:0] st_res_q;
  logic [7:0] rdata_q;
  aob_st_e st_state_q;
  logic [9:0] st_cnt_q;
  logic st_start;
  logic st_last;
  logic [15:0] st_crc;
  logic [11:0] st_pn;
  logic [11:0] pn_long;
  logic [11:0] pn_short;
  logic alt_q;
  logic [3:0] pat_sel;
  logic pat_off;
  logic [11:0] pat_word;
  aob_sample_s src;
  aob_fmt_e eff_fmt;
  logic [11:0] fmt_word;
  aob_sample_s pipe_q [LATENCY];
  logic [11:0] data_q;
  logic ovr_q;
  logic oe_q;
  logic fclk_q;
  logic out_dis_func;
  logic pdown;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  function automatic logic [11:0] fmt_code(input logic [11:0] ob, input aob_fmt_e f);
    case (f)
      AOB_FMT_TWOS: return {~ob[11], ob[10:0]};
      AOB_FMT_GRAY: return ob ^ {1'b0, ob[11:1]};
      default: return ob;
    endcase
  endfunction

  // Every pin crosses two flip-flops; the core word is assumed settled
  // well before the sample edge, since no handshake exists to protect it.
  assign pin_in = '{sclk: sample_clk_pin, over: core_over, under: core_under,
                    code: core_code, out_dis: output_disable_pin,
                    fmt: format_select_pin, pdown: powerdown_select_pin};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      sclk_d_q <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      sclk_d_q <= pin_s2_q.sclk;
    end
  end

  assign sample_rise = pin_s2_q.sclk & ~sclk_d_q;

  // Register writes.
  assign st_start = reg_wr && hit(reg_addr, `AOB_ADDR_ST_CTRL) &&
                    reg_wdata[`AOB_ST_EN_BIT] && st_state_q == AOB_ST_IDLE;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_mode_q <= `AOB_REG_RST;
      test_pat_q <= `AOB_REG_RST;
    end
    else if (ce && reg_wr)
    begin
      if (hit(reg_addr, `AOB_ADDR_OUT_MODE))
        out_mode_q <= reg_wdata;
      if (hit(reg_addr, `AOB_ADDR_TEST_PAT))
        test_pat_q <= reg_wdata;
    end
  end

  // A software write in the completion cycle wins, so its enable bit is kept, though no new run starts.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ctrl_q <= `AOB_REG_RST;
    else if (ce)
    begin
      if (reg_wr && hit(reg_addr, `AOB_ADDR_ST_CTRL))
        st_ctrl_q <= reg_wdata;
      else if (st_state_q == AOB_ST_CHECK)
        st_ctrl_q[`AOB_ST_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= `AOB_REG_RST;
    else if (ce && reg_rd)
    begin
      if (hit(reg_addr, `AOB_ADDR_OUT_MODE))
        rdata_q <= out_mode_q;
      else if (hit(reg_addr, `AOB_ADDR_TEST_PAT))
        rdata_q <= test_pat_q;
      else if (hit(reg_addr, `AOB_ADDR_ST_CTRL))
        rdata_q <= st_ctrl_q;
      else if (hit(reg_addr, `AOB_ADDR_ST_RES))
        rdata_q <= st_res_q;
      else
        rdata_q <= `AOB_REG_RST;
    end
  end

  assign reg_rdata = rdata_q;

  // Self-test sequencer.
  assign st_last = st_cnt_q == 10'(`AOB_ST_CYCLES - 11'd1);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_state_q <= AOB_ST_IDLE;
      st_cnt_q <= 10'd0;
    end
    else if (ce)
    begin
      case (st_state_q)
        AOB_ST_IDLE:
        begin
          st_cnt_q <= 10'd0;
          if (st_start)
            st_state_q <= AOB_ST_RUN;
        end
        AOB_ST_RUN:
        begin
          if (sample_rise)
          begin
            st_cnt_q <= st_cnt_q + 10'd1;
            if (st_last)
              st_state_q <= AOB_ST_CHECK;
          end
        end
        AOB_ST_CHECK:
          st_state_q <= AOB_ST_IDLE;
        default:
          st_state_q <= AOB_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_res_q <= `AOB_REG_RST;
    else if (ce && st_state_q == AOB_ST_CHECK)
      st_res_q[`AOB_ST_PASS_BIT] <= st_crc == ST_SIGNATURE;
  end

  // Reseeding only on a restart start; otherwise the sequence carries on.
  aob_pn_gen #(
    .W(16),
    .TAPS(`AOB_ST_PN_TAPS),
    .SEED(`AOB_ST_PN_SEED),
    .OW(12)
  ) u_st_pn (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .seed(st_start && reg_wdata[`AOB_ST_RESTART_BIT]),
    .adv(st_state_q == AOB_ST_RUN && sample_rise),
    .word(st_pn)
  );

  aob_crc #(
    .W(16),
    .POLY(`AOB_CRC_POLY),
    .SEED(`AOB_CRC_SEED),
    .DW(12)
  ) u_st_crc (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .clear(st_start),
    .en(st_state_q == AOB_ST_RUN && sample_rise),
    .data(fmt_word),
    .crc(st_crc)
  );

  // Output test patterns.
  assign pat_sel = test_pat_q[`AOB_PAT_MSB:0];
  assign pat_off = pat_sel == `AOB_PAT_OFF;

  aob_pn_gen #(
    .W(23),
    .TAPS(`AOB_PN_LONG_TAPS),
    .SEED(`AOB_PN_LONG_SEED),
    .OW(12)
  ) u_pn_long (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .seed(test_pat_q[`AOB_PN_LONG_RST_BIT]),
    .adv(sample_rise),
    .word(pn_long)
  );

  aob_pn_gen #(
    .W(15),
    .TAPS(`AOB_PN_SHORT_TAPS),
    .SEED(`AOB_PN_SHORT_SEED),
    .OW(12)
  ) u_pn_short (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .seed(test_pat_q[`AOB_PN_SHORT_RST_BIT]),
    .adv(sample_rise),
    .word(pn_short)
  );

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      alt_q <= 1'b0;
    else if (ce && sample_rise)
      alt_q <= ~alt_q;
  end

  always_comb
  begin
    case (pat_sel)
      `AOB_PAT_MID: pat_word = `AOB_CODE_MID;
      `AOB_PAT_POS_FS: pat_word = `AOB_CODE_MAX;
      `AOB_PAT_NEG_FS: pat_word = `AOB_CODE_MIN;
      `AOB_PAT_CHECKER: pat_word = alt_q ? ~`AOB_CODE_CHECKER : `AOB_CODE_CHECKER;
      `AOB_PAT_PN_LONG: pat_word = pn_long;
      `AOB_PAT_PN_SHORT: pat_word = pn_short;
      `AOB_PAT_TOGGLE: pat_word = alt_q ? `AOB_CODE_MAX : `AOB_CODE_MIN;
      default: pat_word = `AOB_CODE_MID;
    endcase
  end

  // Source select: self-test, then test pattern, then the core.
  always_comb
  begin
    src = '{ovr: 1'b0, code: pin_s2_q.code};
    if (st_state_q == AOB_ST_RUN)
      src.code = st_pn;
    else if (!pat_off)
      src.code = pat_word;
    else if (pin_s2_q.over)
      src = '{ovr: 1'b1, code: `AOB_CODE_MAX};
    else if (pin_s2_q.under)
      src = '{ovr: 1'b1, code: `AOB_CODE_MIN};
  end

  always_comb
  begin
    if (serial_mode)
      eff_fmt = aob_fmt_e'(fmt_cfg);
    else if (pin_s2_q.fmt)
      eff_fmt = AOB_FMT_TWOS;
    else
      eff_fmt = AOB_FMT_OFFSET;
  end

  assign fmt_word = fmt_code(src.code, eff_fmt);

  // Pipeline: stage 0 on edge k, output register on edge k + LATENCY.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pipe_q[0] <= '0;
    else if (ce && sample_rise)
      pipe_q[0] <= '{ovr: src.ovr, code: fmt_word};
  end

  for (genvar g = 1; g < LATENCY; g++)
  begin : g_pipe
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
        pipe_q[g] <= '0;
      else if (ce && sample_rise)
        pipe_q[g] <= pipe_q[g-1];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_q <= `AOB_CODE_MIN;
      ovr_q <= 1'b0;
    end
    else if (ce && sample_rise)
    begin
      data_q <= pipe_q[LATENCY-1].code;
      ovr_q <= pipe_q[LATENCY-1].ovr;
    end
  end

  // Drivers; self-test never gates them, so the sequence stays visible.
  assign out_dis_func = out_mode_q[`AOB_OUT_DIS_MSB:`AOB_OUT_DIS_LSB] ==
                        `AOB_OUT_DIS_PIN_MODE;
  assign pdown = !serial_mode && pin_s2_q.pdown;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_q <= 1'b0;
      fclk_q <= 1'b0;
    end
    else if (ce)
    begin
      oe_q <= !pdown && !(out_dis_func && pin_s2_q.out_dis);
      fclk_q <= ~pin_s2_q.sclk ^ fwd_clk_invert;
    end
  end

  assign data_out = data_q;
  assign over_range_out = ovr_q;
  assign bus_oe = oe_q;
  assign fwd_clk_oe = oe_q;
  assign forwarded_data_clock = fclk_q;

  logic [10:0] chk_cnt_q;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      chk_cnt_q <= 11'd0;
    else if (ce && st_state_q == AOB_ST_IDLE)
      chk_cnt_q <= 11'd0;
    else if (ce && st_state_q == AOB_ST_RUN && sample_rise)
      chk_cnt_q <= chk_cnt_q + 11'd1;
  end

  st_length_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_state_q == AOB_ST_CHECK |-> chk_cnt_q == `AOB_ST_CYCLES)
    else $error("self-test length wrong");
  st_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && st_state_q == AOB_ST_CHECK && st_crc == ST_SIGNATURE |=> st_res_q[0])
    else $error("pass bit not set");
  st_fail_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && st_state_q == AOB_ST_CHECK && st_crc != ST_SIGNATURE |=> !st_res_q[0])
    else $error("pass bit not cleared");
  en_autoclear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && st_state_q == AOB_ST_CHECK && !reg_wr |=> !st_ctrl_q[0] && st_state_q == AOB_ST_IDLE)
    else $error("enable not cleared");
  out_disable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && out_dis_func && pin_s2_q.out_dis |=> !bus_oe && !fwd_clk_oe)
    else $error("outputs not floated");
  pin_ignored_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && !out_dis_func && !pdown |=> bus_oe)
    else $error("disable pin acted while off");
  pdown_float_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && pdown |=> !bus_oe)
    else $error("drivers on in power-down");
  ovr_clamp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && sample_rise && st_state_q == AOB_ST_IDLE && pat_off && eff_fmt == AOB_FMT_OFFSET
    && pin_s2_q.over |=> pipe_q[0].ovr && pipe_q[0].code == `AOB_CODE_MAX)
    else $error("over-range not clamped");
  in_range_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && sample_rise && pat_off && !pin_s2_q.over && !pin_s2_q.under |=> !pipe_q[0].ovr)
    else $error("flag set in range");
  latency_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && sample_rise |=> data_q == $past(pipe_q[LATENCY-1].code))
    else $error("output not from last stage");
  pat_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && !sample_rise && !test_pat_q[`AOB_PN_LONG_RST_BIT] |=> $stable(pn_long))
    else $error("pattern moved without edge");
endmodule
`default_nettype wire

// File: aob_capture_model.sv
`default_nettype none
module aob_capture_model
  import aob_pkg::*;
(
  // Bus from the converter
  input wire logic forwarded_data_clock,
  input wire logic fwd_clk_invert,
  input wire logic bus_oe,
  input wire logic [11:0] data_out,
  input wire logic over_range_out,
  // Captured word
  output aob_sample_s captured
);
  timeunit 1ns;
  timeprecision 1ps;
  aob_sample_s last_s;
  aob_sample_s wire_s;
  logic cap_clk;
  initial last_s = '0;
  initial captured = '0;
  // A released bus holds no value, so the inverse of the last driven word shows.
  always @(bus_oe, data_out, over_range_out)
    if (bus_oe)
      last_s = aob_sample_s'({over_range_out, data_out});
  assign wire_s = bus_oe ? aob_sample_s'({over_range_out, data_out}) : aob_sample_s'(~last_s);
  assign cap_clk = forwarded_data_clock ^ fwd_clk_invert;
  always @(posedge cap_clk)
    captured <= wire_s;
endmodule
`default_nettype wire

// File: aob_backend_tb.sv
`default_nettype none
`include "aob_params.svh"
module aob_backend_tb
  import aob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, arst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic serial_mode = 0, fwd_clk_invert = 0, sample_clk_pin = 0;
  logic [1:0] fmt_cfg = '0;
  logic [11:0] core_code = '0, data_out;
  logic core_over = 0, core_under = 0, output_disable_pin = 0;
  logic format_select_pin = 0, powerdown_select_pin = 0;
  logic over_range_out, bus_oe, forwarded_data_clock, fwd_clk_oe;
  aob_sample_s captured;
  int n_errors = 0, n_checks = 0;
  logic [7:0] v, r1, r2;
  logic [11:0] a, b, hold;
  logic [1:0] mode;
  logic [12:0] ex;
  logic [7:0] reg_list [5] = '{8'h08, 8'h0d, 8'h0e, 8'h24, 8'h55};
  logic [11:0] codes [3] = '{12'h000, 12'h800, 12'hfff};
  always #4 ref_clk = ~ref_clk;
  // The sample clock is twenty ref_clk periods long; its edges fall on ref_clk falling edges.
  always #80 sample_clk_pin = ~sample_clk_pin;
  // Signature of 512 generator words after skipping the first ones, offset binary format.
  function automatic logic [15:0] st_sig(int skip);
    logic [15:0] pn;
    logic [15:0] crc;
    logic fb;
    pn = `AOB_ST_PN_SEED;
    crc = `AOB_CRC_SEED;
    for (int n = 0; n < skip + 512; n++)
    begin
      if (n >= skip)
        for (int i = 11; i >= 0; i--)
        begin
          fb = crc[15] ^ pn[i];
          crc = {crc[14:0], 1'b0} ^ (fb ? `AOB_CRC_POLY : 16'h0000);
        end
      pn = {pn[14:0], ^(pn & `AOB_ST_PN_TAPS)};
    end
    return crc;
  endfunction
  localparam logic [15:0] ST_SIG_TB = st_sig(0);
  aob_backend #(.ST_SIGNATURE(ST_SIG_TB))
  dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_mode(serial_mode), .fmt_cfg(fmt_cfg), .fwd_clk_invert(fwd_clk_invert),
    .sample_clk_pin(sample_clk_pin), .core_code(core_code), .core_over(core_over),
    .core_under(core_under), .output_disable_pin(output_disable_pin),
    .format_select_pin(format_select_pin), .powerdown_select_pin(powerdown_select_pin),
    .data_out(data_out), .over_range_out(over_range_out), .bus_oe(bus_oe),
    .forwarded_data_clock(forwarded_data_clock), .fwd_clk_oe(fwd_clk_oe));
  aob_capture_model cap_u (.forwarded_data_clock(forwarded_data_clock),
    .fwd_clk_invert(fwd_clk_invert), .bus_oe(bus_oe), .data_out(data_out),
    .over_range_out(over_range_out), .captured(captured));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [7:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic wait_samples(int n);
    repeat (n) @(posedge sample_clk_pin);
    repeat (6) @(posedge ref_clk);
  endtask
  // New core input just after the sample pin falls, so the next rise takes it.
  task automatic new_sample(logic [11:0] c, logic ov, logic un);
    @(negedge sample_clk_pin);
    @(posedge ref_clk);
    core_code <= c;
    core_over <= ov;
    core_under <= un;
  endtask
  function automatic logic [12:0] expect_out(logic [11:0] c, logic ov, logic un,
      logic [1:0] m);
    logic [11:0] w;
    w = ov ? 12'hfff : (un ? 12'h000 : c);
    case (m)
      2'b01: w = w ^ 12'h800;
      2'b10: w = w ^ (w >> 1);
      default: w = w;
    endcase
    return {ov | un, w};
  endfunction
  task automatic self_test(logic [7:0] cmd, output logic [7:0] res);
    wr(8'h0e, cmd);
    rd(8'h0e, v);
    check("st enable", 16'(v[0]), 16'h0001);
    hold = data_out;
    wait_samples(40);
    check("st bus on", 16'({bus_oe, data_out !== hold}), 16'h0003);
    wait_samples(463);
    rd(8'h0e, v);
    check("st busy", 16'(v[0]), 16'h0001);
    wait_samples(17);
    rd(8'h0e, v);
    check("st done", 16'(v[0]), 16'h0000);
    rd(8'h24, res);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    give_verdict();
  end
  initial
  begin
    void'($urandom(15721));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1;
    foreach (reg_list[i])
    begin
      rd(reg_list[i], v);
      check("reset value", 16'(v), 16'h0000);
    end
    wr(8'h24, 8'hff);
    rd(8'h24, v);
    check("read only", 16'(v), 16'h0000);
    wr(8'h55, 8'hff);
    rd(8'h55, v);
    check("unmapped", 16'(v), 16'h0000);
    v = 8'($urandom) & 8'h9f;
    wr(8'h08, v);
    rd(8'h08, r1);
    check("out mode rw", 16'(r1), 16'(v));
    wr(8'h08, 8'h00);
    a = 12'($urandom);
    b = ~a;
    new_sample(a, 0, 0);
    wait_samples(11);
    new_sample(b, 0, 0);
    wait_samples(9);
    check("latency old", 16'(data_out), 16'(a));
    wait_samples(1);
    check("latency new", 16'(data_out), 16'(b));
    for (int k = 0; k < 12; k++)
    begin
      a = (k < 3) ? codes[k] : 12'($urandom);
      serial_mode <= k[0];
      format_select_pin <= k[1];
      fmt_cfg <= 2'(k % 3);
      fwd_clk_invert <= k[2];
      mode = k[0] ? 2'(k % 3) : {1'b0, k[1]};
      new_sample(a, k == 5, k == 9);
      wait_samples(11);
      ex = expect_out(a, k == 5, k == 9, mode);
      check("format", 16'({over_range_out, data_out}), 16'(ex));
      check("captured", 16'(captured), 16'(ex));
    end
    serial_mode <= 0;
    format_select_pin <= 0;
    output_disable_pin <= 1;
    wait_samples(1);
    check("oe pin high", 16'({bus_oe, fwd_clk_oe}), 16'h0000);
    wr(8'h08, 8'h20);
    wait_samples(1);
    check("oe pin off", 16'({bus_oe, fwd_clk_oe}), 16'h0003);
    wr(8'h08, 8'h00);
    output_disable_pin <= 0;
    powerdown_select_pin <= 1;
    wait_samples(1);
    check("powerdown", 16'({bus_oe, fwd_clk_oe}), 16'h0000);
    powerdown_select_pin <= 0;
    new_sample(12'($urandom), 1, 0);
    for (int p = 1; p < 4; p++)
    begin
      wr(8'h0d, 8'(p));
      wait_samples(11);
      check("pattern", 16'({over_range_out, data_out}), 16'(codes[p % 3]));
    end
    wr(8'h0d, 8'h04);
    wait_samples(11);
    check("checker", 16'((data_out === 12'haaa) || (data_out === 12'h555)), 16'h0001);
    wr(8'h0d, 8'h25);
    wait_samples(11);
    hold = data_out;
    wait_samples(3);
    check("pn held", 16'(data_out), 16'(hold));
    wr(8'h0d, 8'h05);
    wait_samples(11);
    check("pn runs", 16'(data_out !== hold), 16'h0001);
    wr(8'h0d, 8'h00);
    self_test(8'h05, r1);
    check("st pass", 16'(r1[0]), 16'h0001);
    self_test(8'h05, r2);
    check("st repeat", 16'(r2), 16'(r1));
    self_test(8'h01, r2);
    check("st continue", 16'(r2[0]), 16'(st_sig(512) == ST_SIG_TB));
    give_verdict();
  end
endmodule
`default_nettype wire
